// file: rtl/baso_core.sv
// Byte ALU datapath with APB register access
//
// Functional notes
// RL1: pointer add sign-extends 6-bit literal, flags untouched
// RL2: pointer sum wraps modulo 65536
// RL3: add literal to accumulator, update C DC Z
// RL4: and literal with accumulator, only Z
// RL5: register address 0..127, dest bit routes
// RL6: and accumulator with register, only Z
// RL7: add accumulator and register, C DC Z
// RL8: add with carry includes current carry
// RL9: arithmetic shift right, bit0 to carry
// RL10: Z on zero result, carries bit7/bit3
// RL11: unlisted flags hold; one cycle execution
`timescale 1ns/10ps
`include "baso_regs.svh"
module baso_core (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic      [6:0]  freg_addr_o,
   output logic      [7:0]  freg_wdata_o,
   output logic             freg_we_o,
   input  wire logic [7:0]  freg_rdata_i
);
   logic [7:0]  acc, next_acc;
   logic        c_flag, next_c_flag;
   logic        digit_carry_flag, next_digit_carry_flag;
   logic        z_flag, next_z_flag;
   logic        fwr_done, next_fwr_done;
   logic [15:0] ptr0, next_ptr0;
   logic [15:0] ptr1, next_ptr1;
   logic [7:0]  opnd, next_opnd;
   logic [2:0]  op, next_op;
   logic        dst, next_dst;
   logic        psel_ptr, next_psel_ptr;
   logic [7:0]  fres, next_fres;
   logic [6:0]  faddr, next_faddr;
   logic [7:0]  fwdata, next_fwdata;
   logic        fwe, next_fwe;
   logic [31:0] rdata, next_rdata;
   logic        ready, next_ready;
   logic        slverr, next_slverr;
   logic [7:0]  alu_res;
   logic        alu_c, alu_dc, alu_z;
   logic [7:0]  alu_b;
   logic [15:0] ptr_sum;
   logic        go;
   logic        acc_phase;
   logic        wr_commit;
   logic        wr_acc;

   // True for ops whose second operand comes from the file register
   function automatic logic is_reg_op(input logic [2:0] o);
      is_reg_op = (o == baso_pkg::BASO_OP_AND_REG) || (o == baso_pkg::BASO_OP_ADD_REG) ||
                  (o == baso_pkg::BASO_OP_ADDC_REG) || (o == baso_pkg::BASO_OP_ASR_REG);
   endfunction

   baso_alu8 u_alu (
      .op_i   (op),
      .acc_i  (acc),
      .opnd_i (alu_b),
      .c_i    (c_flag),
      .res_o  (alu_res),
      .c_o    (alu_c),
      .dc_o   (alu_dc),
      .z_o    (alu_z)
   );

   baso_ptr_add u_ptr (
      .ptr_i (psel_ptr ? ptr1 : ptr0),
      .lit_i (opnd[5:0]),
      .sum_o (ptr_sum)
   );

   // Register operand is the live read data for the addressed file register
   always_comb begin
      alu_b = is_reg_op(op) ? freg_rdata_i : opnd;
   end

   // APB: one wait state; read word registered at the first access edge
   // Writes land only at the edge where the master sees pready high
   always_comb begin
      acc_phase = psel_i && penable_i && !ready;
      wr_commit = psel_i && penable_i && ready && pwrite_i;
      next_ready = acc_phase;
      next_slverr = 1'b0;
      next_rdata = 32'h0000_0000;
      go = 1'b0;
      next_op = op;
      next_dst = dst;
      next_psel_ptr = psel_ptr;
      next_opnd = opnd;
      next_faddr = faddr;
      if (acc_phase) begin
         case (paddr_i)
            `BASO_REG_CTRL: next_rdata = {26'h0, psel_ptr, dst, 1'b0, op};
            `BASO_REG_OPND: next_rdata = {17'h0, faddr, opnd};
            `BASO_REG_ACC: next_rdata = {24'h0, acc};
            `BASO_REG_STATUS: next_rdata = {28'h0, fwr_done, z_flag, digit_carry_flag, c_flag};
            `BASO_REG_PTR0: next_rdata = {16'h0, ptr0};
            `BASO_REG_PTR1: next_rdata = {16'h0, ptr1};
            `BASO_REG_FRES: next_rdata = {24'h0, fres};
            default: next_slverr = 1'b1;
         endcase
      end
      if (wr_commit) begin
         case (paddr_i)
            `BASO_REG_CTRL: begin
               next_op = pwdata_i[`BASO_CTRL_OP_LSB +: 3];
               next_dst = pwdata_i[`BASO_CTRL_DST]; // RL5
               next_psel_ptr = pwdata_i[`BASO_CTRL_PSEL];
               go = pwdata_i[`BASO_CTRL_GO];
            end
            `BASO_REG_OPND: begin
               next_opnd = pwdata_i[7:0];
               next_faddr = pwdata_i[14:8]; // RL5
            end
            default: begin
            end
         endcase
      end
   end

   // Execution: one instruction per go pulse; acc and flags update at the go edge, file register write lands one edge later
   always_comb begin
      next_acc = acc;
      next_c_flag = c_flag; // RL11
      next_digit_carry_flag = digit_carry_flag; // RL11
      next_z_flag = z_flag; // RL11
      next_ptr0 = ptr0;
      next_ptr1 = ptr1;
      next_fres = fres;
      next_fwdata = fwdata;
      next_fwe = 1'b0;
      next_fwr_done = fwr_done;
      wr_acc = 1'b0;
      if (wr_commit && paddr_i == `BASO_REG_ACC) begin
         next_acc = pwdata_i[7:0];
      end
      if (wr_commit && paddr_i == `BASO_REG_STATUS) begin
         next_c_flag = pwdata_i[`BASO_ST_C];
         next_digit_carry_flag = pwdata_i[`BASO_ST_DC];
         next_z_flag = pwdata_i[`BASO_ST_Z];
      end
      if (wr_commit && paddr_i == `BASO_REG_PTR0) begin
         next_ptr0 = pwdata_i[15:0];
      end
      if (wr_commit && paddr_i == `BASO_REG_PTR1) begin
         next_ptr1 = pwdata_i[15:0];
      end
      if (go) begin
         next_fwr_done = 1'b0;
         case (op)
            baso_pkg::BASO_OP_PTR_ADD: begin
               if (psel_ptr) begin
                  next_ptr1 = ptr_sum; // RL1 RL2 RL11
               end else begin
                  next_ptr0 = ptr_sum; // RL1 RL2 RL11
               end
            end
            baso_pkg::BASO_OP_ADD_LIT: begin
               wr_acc = 1'b1; // RL3
               next_c_flag = alu_c; // RL3
               next_digit_carry_flag = alu_dc; // RL3
               next_z_flag = alu_z; // RL3
            end
            baso_pkg::BASO_OP_AND_LIT: begin
               wr_acc = 1'b1; // RL4
               next_z_flag = alu_z; // RL4
            end
            baso_pkg::BASO_OP_AND_REG: begin
               wr_acc = !dst; // RL5 RL6
               next_z_flag = alu_z; // RL6
            end
            baso_pkg::BASO_OP_ADD_REG,
            baso_pkg::BASO_OP_ADDC_REG: begin
               wr_acc = !dst; // RL5 RL7 RL8
               next_c_flag = alu_c; // RL7 RL8
               next_digit_carry_flag = alu_dc; // RL7 RL8
               next_z_flag = alu_z; // RL7 RL8
            end
            baso_pkg::BASO_OP_ASR_REG: begin
               wr_acc = !dst; // RL9
               next_c_flag = alu_c; // RL9
               next_z_flag = alu_z; // RL9
            end
            default: begin
            end
         endcase
         if (op != baso_pkg::BASO_OP_PTR_ADD && op != baso_pkg::BASO_OP_NONE) begin
            next_fres = alu_res;
         end
         if (is_reg_op(op) && dst) begin
            next_fwdata = alu_res; // RL5 RL11
            next_fwe = 1'b1; // RL5 RL11
            next_fwr_done = 1'b1;
         end
      end
      if (wr_acc) begin
         next_acc = alu_res;
      end
   end

   // Bus side state
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         opnd <= 8'h00;
         op <= baso_pkg::BASO_OP_NONE;
         dst <= 1'b0;
         psel_ptr <= 1'b0;
         faddr <= 7'h00;
         rdata <= 32'h0000_0000;
         ready <= 1'b0;
         slverr <= 1'b0;
      end else begin
         opnd <= next_opnd;
         op <= next_op;
         dst <= next_dst;
         psel_ptr <= next_psel_ptr;
         faddr <= next_faddr;
         rdata <= next_rdata;
         ready <= next_ready;
         slverr <= next_slverr;
      end
   end

   // Datapath state
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         acc <= `BASO_ACC_RST;
         c_flag <= 1'b0;
         digit_carry_flag <= 1'b0;
         z_flag <= 1'b0;
         fwr_done <= 1'b0;
         ptr0 <= `BASO_PTR_RST;
         ptr1 <= `BASO_PTR_RST;
         fres <= 8'h00;
         fwdata <= 8'h00;
         fwe <= 1'b0;
      end else begin
         acc <= next_acc;
         c_flag <= next_c_flag;
         digit_carry_flag <= next_digit_carry_flag;
         z_flag <= next_z_flag;
         fwr_done <= next_fwr_done;
         ptr0 <= next_ptr0;
         ptr1 <= next_ptr1;
         fres <= next_fres;
         fwdata <= next_fwdata;
         fwe <= next_fwe;
      end
   end

   always_comb begin
      prdata_o = rdata;
      pready_o = ready;
      pslverr_o = slverr;
      freg_addr_o = faddr;
      freg_wdata_o = fwdata;
      freg_we_o = fwe;
   end
endmodule

// file: rtl/baso_regs.svh
// Constants for the byte ALU datapath
`ifndef BASO_REGS_SVH
`define BASO_REGS_SVH
`define BASO_ADDR_BASE   32'h0000_0000
`define BASO_REG_CTRL    12'h000
`define BASO_REG_OPND    12'h004
`define BASO_REG_ACC     12'h008
`define BASO_REG_STATUS  12'h00C
`define BASO_REG_PTR0    12'h010
`define BASO_REG_PTR1    12'h014
`define BASO_REG_FRES    12'h018
`define BASO_CTRL_OP_LSB 0
`define BASO_CTRL_DST    4
`define BASO_CTRL_PSEL   5
`define BASO_CTRL_GO     8
`define BASO_ST_C        0
`define BASO_ST_DC       1
`define BASO_ST_Z        2
`define BASO_ST_FWR      3
`define BASO_ACC_RST     8'h00
`define BASO_PTR_RST     16'h0000
`define BASO_EXEC_CYC    1
`endif

// file: rtl/baso_pkg.sv
// Types for the byte ALU datapath
package baso_pkg;
   typedef enum logic [2:0] {
      BASO_OP_NONE      = 3'h0,
      BASO_OP_PTR_ADD   = 3'h1,
      BASO_OP_ADD_LIT   = 3'h2,
      BASO_OP_AND_LIT   = 3'h3,
      BASO_OP_AND_REG   = 3'h4,
      BASO_OP_ADD_REG   = 3'h5,
      BASO_OP_ADDC_REG  = 3'h6,
      BASO_OP_ASR_REG   = 3'h7
   } baso_op_e;
   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       dc;
      logic       z;
   } baso_alu_s;
endpackage

// file: rtl/baso_alu8.sv
// 8-bit add, and, shift unit with flag outputs
`timescale 1ns/10ps
module baso_alu8 (
   input  wire logic [2:0] op_i,
   input  wire logic [7:0] acc_i,
   input  wire logic [7:0] opnd_i,
   input  wire logic       c_i,
   output logic      [7:0] res_o,
   output logic            c_o,
   output logic            dc_o,
   output logic            z_o
);
   logic [4:0] lo_sum;
   logic [8:0] full_sum;
   logic       cin;
   always_comb begin
      cin = (op_i == baso_pkg::BASO_OP_ADDC_REG) ? c_i : 1'b0; // RL8
      lo_sum = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]} + {4'h0, cin};
      full_sum = {1'b0, acc_i} + {1'b0, opnd_i} + {8'h00, cin};
      res_o = full_sum[7:0];
      c_o = full_sum[8]; // RL10
      dc_o = lo_sum[4]; // RL10
      case (op_i)
         baso_pkg::BASO_OP_AND_LIT,
         baso_pkg::BASO_OP_AND_REG: begin
            res_o = acc_i & opnd_i; // RL4 RL6
         end
         baso_pkg::BASO_OP_ASR_REG: begin
            res_o = {opnd_i[7], opnd_i[7:1]}; // RL9
            c_o = opnd_i[0]; // RL9
         end
         default: begin
         end
      endcase
      z_o = (res_o == 8'h00); // RL10
   end
endmodule

// file: rtl/baso_ptr_add.sv
// Signed 6-bit literal added to a 16-bit pointer, wrapping
`timescale 1ns/10ps
module baso_ptr_add (
   input  wire logic [15:0] ptr_i,
   input  wire logic [5:0]  lit_i,
   output logic      [15:0] sum_o
);
   always_comb begin
      sum_o = ptr_i + {{10{lit_i[5]}}, lit_i}; // RL1 RL2
   end
endmodule

// file: bench/baso_freg_model.sv
// File register space model on the far side of the datapath
`timescale 1ns/10ps
module baso_freg_model (
   input  wire logic       clk_i,
   input  wire logic [6:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       we_i,
   output logic      [7:0] rdata_o
);
   logic [7:0] mem [128];
   // Distinct preload so a wrong address shows up in results
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 29 + 90);
   // Read is combinational: the core samples it in the go cycle
   assign rdata_o = mem[addr_i];
   always @(posedge clk_i) if (we_i) mem[addr_i] <= wdata_i;
endmodule

// file: bench/baso_core_props.sv
// Port-level checker for the byte ALU datapath
`timescale 1ns/10ps
module baso_core_props (
   input wire logic        core_clk_i,
   input wire logic        srst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [6:0]  freg_addr_o,
   input wire logic [7:0]  freg_wdata_o,
   input wire logic        freg_we_o,
   input wire logic [7:0]  freg_rdata_i
);
   logic acc_wr, go_wr, go_wb, opnd_wr;
   // Writes land at the completing edge of the transfer
   assign acc_wr  = psel_i && penable_i && pready_o && pwrite_i;
   assign go_wr   = acc_wr && paddr_i == 12'h000 && pwdata_i[8];
   // Register ops have op bit 2 set
   assign go_wb   = go_wr && pwdata_i[4] && pwdata_i[2];
   assign opnd_wr = acc_wr && paddr_i == 12'h004;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   chk_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("no ready");
   chk_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held");
   chk_ready_cause: assert property (pready_o |-> $past(penable_i)) else $error("stray ready");
   chk_err_data: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad err");
   chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("data leak");
   chk_we_follow: assert property (go_wb |=> freg_we_o) else $error("no write-back");
   chk_we_cause: assert property (freg_we_o |-> $past(go_wb)) else $error("stray write");
   chk_lit_no_wb: assert property (go_wr && !pwdata_i[2] |=> !freg_we_o) else $error("literal wrote");
   chk_addr_hold: assert property (!$stable(freg_addr_o) |-> $past(opnd_wr)) else $error("addr moved");
   cover property (go_wb ##1 freg_we_o);
   cover property (pslverr_o);
   cover property (opnd_wr ##[1:20] go_wr);
endmodule
bind baso_core baso_core_props u_props (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .freg_addr_o, .freg_wdata_o, .freg_we_o, .freg_rdata_i);

// file: bench/byte_alu_add_and_shift_ops_test.sv
// Self-checking bench for the byte ALU datapath
`timescale 1ns/10ps
`include "baso_regs.svh"
module byte_alu_add_and_shift_ops_test;
   logic        core_clk_i = 1'b0, srst_i = 1'b1;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd, rnd;
   logic        pready_o, pslverr_o, freg_we_o, err, c, dc, z, fwr;
   logic [6:0]  freg_addr_o;
   logic [7:0]  freg_wdata_o, freg_rdata_i, acc;
   logic [7:0]  mem [128];
   logic [15:0] ptr [2];
   int          num_errors = 0, checks_done = 0, seed = 32'hA8A26ECD;
   baso_pkg::baso_alu_s r;

   always #4 core_clk_i = ~core_clk_i;

   baso_core dut (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
                  .pready_o, .pslverr_o, .freg_addr_o, .freg_wdata_o, .freg_we_o, .freg_rdata_i);
   baso_freg_model u_mem (.clk_i(core_clk_i), .addr_i(freg_addr_o), .wdata_i(freg_wdata_o),
                          .we_i(freg_we_o), .rdata_o(freg_rdata_i));

   task finish_test;
      $display("Errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   // Outputs read right at the edge, before that edge's updates land
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (pready_o !== 1'b1) chk("pready", 32'h1, 32'h0);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   function automatic baso_pkg::baso_alu_s calc(input logic [2:0] op, input logic [7:0] a, b, input logic ci);
      logic [8:0] s;
      logic       cin;
      baso_pkg::baso_alu_s o;
      cin = (op == 3'h6) ? ci : 1'b0;
      s = 9'(a) + 9'(b) + 9'(cin);
      o.res = s[7:0];
      o.c = s[8];
      o.dc = (5'(a[3:0]) + 5'(b[3:0]) + 5'(cin)) > 5'h0F;
      if (op == 3'h3 || op == 3'h4) o.res = a & b;
      if (op == 3'h7) begin
         o.res = {b[7], b[7:1]};
         o.c = b[0];
      end
      o.z = (o.res == 8'h00);
      return o;
   endfunction

   task do_op(input logic [2:0] op, input logic dst, ps, input logic [7:0] k, input logic [6:0] fa);
      logic [31:0] ctl;
      ctl = {26'h0, ps, dst, 1'b0, op};
      apb(1'b1, `BASO_REG_OPND, {17'h0, fa, k});
      // Op is latched by the first write, go by the second
      apb(1'b1, `BASO_REG_CTRL, ctl);
      apb(1'b1, `BASO_REG_CTRL, ctl | 32'h0000_0100);
      r = calc(op, acc, (op == 3'h2 || op == 3'h3) ? k : mem[fa], c);
      fwr = op[2] & dst;
      if (op == 3'h1) ptr[ps] = ptr[ps] + {{10{k[5]}}, k[5:0]};
      else if (op != 3'h0) begin
         if (fwr) mem[fa] = r.res;
         else acc = r.res;
         z = r.z;
         if (op != 3'h3 && op != 3'h4) c = r.c;
         if (op == 3'h2 || op == 3'h5 || op == 3'h6) dc = r.dc;
      end
      apb(1'b0, `BASO_REG_ACC, 32'h0);
      chk("acc", {24'h0, acc}, rd);
      apb(1'b0, `BASO_REG_STATUS, 32'h0);
      chk("status", {28'h0, fwr, z, dc, c}, rd);
      apb(1'b0, ps ? `BASO_REG_PTR1 : `BASO_REG_PTR0, 32'h0);
      chk("ptr", {16'h0, ptr[ps]}, rd);
      chk("freg", {24'h0, mem[fa]}, {24'h0, u_mem.mem[fa]});
   endtask

   initial begin
      repeat (20000) @(posedge core_clk_i);
      chk("watchdog", 32'h1, 32'h0);
      finish_test;
   end

   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'(i * 29 + 90);
      {acc, c, dc, z, fwr} = '0;
      ptr[0] = 16'h0000;
      ptr[1] = 16'h0000;
      repeat (5) @(posedge core_clk_i);
      srst_i <= 1'b0;
      apb(1'b0, `BASO_REG_ACC, 32'h0);
      chk("acc reset", 32'h0, rd);
      apb(1'b0, 12'h01C, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(1'b1, `BASO_REG_PTR0, 32'h0000_FFFF);
      ptr[0] = 16'hFFFF;
      do_op(3'h1, 1'b0, 1'b0, 8'h01, 7'h00);
      do_op(3'h1, 1'b1, 1'b1, 8'h20, 7'h00);
      apb(1'b1, `BASO_REG_ACC, 32'h0000_00FF);
      acc = 8'hFF;
      do_op(3'h2, 1'b0, 1'b0, 8'h01, 7'h00);
      do_op(3'h6, 1'b1, 1'b0, 8'h00, 7'h7F);
      do_op(3'h0, 1'b1, 1'b0, 8'h55, 7'h10);
      for (int i = 0; i < 70; i++) begin
         rnd = $random(seed);
         if (i % 3 == 0) begin
            apb(1'b1, `BASO_REG_ACC, {24'h0, rnd[7:0]});
            apb(1'b1, `BASO_REG_STATUS, {29'h0, rnd[10:8]});
            acc = rnd[7:0];
            {z, dc, c} = rnd[10:8];
         end
         rnd = $random(seed);
         do_op(3'(1 + i % 7), rnd[0], rnd[1], rnd[15:8], rnd[22:16]);
      end
      srst_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      srst_i <= 1'b0;
      apb(1'b0, `BASO_REG_PTR1, 32'h0);
      chk("ptr reset", 32'h0, rd);
      finish_test;
   end
endmodule
